// file: hdl/lsles_pkg.sv
// Package for the low-speed lane error and status register bank
`default_nettype none

package lsles_pkg;

	// ---------------------------------------------------------------
	// Management addressing
	// ---------------------------------------------------------------
	localparam logic [4:0] LSLES_DEV_ADDR = 5'h1E;
	localparam logic [4:0] LSLES_PORT_ADDR_DEF = 5'h00;
	localparam logic [15:0] LSLES_LANE1_OFS = 16'h0012;
	localparam logic [15:0] LSLES_LANE2_OFS = 16'h0013;
	localparam logic [15:0] LSLES_LANE3_OFS = 16'h0014;
	localparam logic [15:0] LSLES_STATUS_OFS = 16'h0015;
	localparam logic [15:0] LSLES_ADDR_RESET = 16'h0000;

	// ---------------------------------------------------------------
	// Reset values and field positions
	// ---------------------------------------------------------------
	localparam logic [15:0] LSLES_COUNT_RESET = 16'hFFFD;
	localparam logic [15:0] LSLES_STATUS_RESET = 16'h0000;
	localparam int LSLES_DECODE_BIT = 11;
	localparam int LSLES_LOS_BIT = 10;
	localparam int LSLES_FIFO_BIT = 9;
	localparam int LSLES_SYNC_BIT = 8;
	localparam int LSLES_ROT_LSB = 0;

	// ---------------------------------------------------------------
	// Frame bit counts and opcodes
	// ---------------------------------------------------------------
	localparam logic [5:0] LSLES_PRE_BITS = 6'h20;
	localparam logic [5:0] LSLES_HDR_LAST = 6'h0B;
	localparam logic [5:0] LSLES_DATA_LAST = 6'h0F;
	localparam logic [1:0] LSLES_OP_ADDR = 2'h0;
	localparam logic [1:0] LSLES_OP_WRITE = 2'h1;
	localparam logic [1:0] LSLES_OP_RINC = 2'h2;
	localparam logic [1:0] LSLES_OP_READ = 2'h3;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		LSLES_MODE_KR_KX,
		LSLES_MODE_10G,
		LSLES_MODE_PATTERN
	} lsles_mode_t;

	typedef enum logic [2:0] {
		S_PRE,
		S_ST,
		S_HDR,
		S_TA1,
		S_TA2,
		S_DATA
	} lsles_state_t;

	// Per-lane conditions from the receive datapath
	typedef struct packed {
		logic decode_err;
		logic align_err;
		logic [3:0] pattern_err;
		logic los;
		logic sync_ok;
	} lsles_lane_in_t;

endpackage

`default_nettype wire

// file: hdl/lsles_err_counter.sv
// Clear-on-read lane error counter with mode-dependent event source
`default_nettype none

module lsles_err_counter
	import lsles_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] RESET_VAL = WIDTH'(LSLES_COUNT_RESET)
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Configuration
	input wire lsles_mode_t mode,
	input wire logic [1:0] pattern_select,
	// Lane events and read strobe
	input wire lsles_lane_in_t lane,
	input wire logic read_clear,
	// Count
	output logic [WIDTH-1:0] count_r
);

	logic hit;
	logic [WIDTH-1:0] count_nxt;

	// Pick the error source for the current mode
	always_comb begin
		case (mode)
			LSLES_MODE_KR_KX: hit = lane.decode_err;
			LSLES_MODE_10G: hit = lane.align_err;
			LSLES_MODE_PATTERN: hit = lane.pattern_err[pattern_select];
			default: hit = 1'b0;
		endcase
	end

	// Count saturates; an event in the clearing cycle is kept
	always_comb begin
		if (read_clear) begin
			count_nxt = hit ? WIDTH'(1) : '0;
		end else if (hit && (count_r != '1)) begin
			count_nxt = count_r + WIDTH'(1);
		end else begin
			count_nxt = count_r;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			count_r <= RESET_VAL;
		end else begin
			count_r <= count_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	clear_on_read_a: assert property ((read_clear && !hit) |=> count_r == '0)
		else $error("counter not cleared by read");
	count_step_a: assert property (
		(!read_clear && hit && count_r != '1) |=> count_r == WIDTH'($past(count_r) + 1'b1))
		else $error("counter did not step on error");
	count_hold_a: assert property ((!read_clear && !hit) |=> $stable(count_r))
		else $error("counter moved without error");
	align_source_a: assert property (
		(mode == LSLES_MODE_10G && !lane.align_err && !read_clear) |=> $stable(count_r))
		else $error("10G counter used wrong source");
	pattern_source_a: assert property (
		(mode == LSLES_MODE_PATTERN && lane.pattern_err[pattern_select] && !read_clear
		&& count_r != '1) |=> count_r != $past(count_r))
		else $error("selected pattern error not counted");

endmodule // lsles_err_counter

`default_nettype wire

// file: hdl/lsles_regs.sv
// Low-speed lane error counters and status behind the management pins
// Functional notes
// - Lanes 1, 2 and 3 each have their own 16-bit error counter register.
// - In backplane modes a counter steps on every invalid or disparity-bad code word.
// - In 10G mode a counter steps on invalid words seen by the alignment decoder.
// - In pattern check mode a counter steps on errors of the pattern chosen by select 5:4.
// - Reading a counter returns its value and then clears it to zero, or to one if an error arrives in the reading cycle.
// - The lane 2 counter sits at 0x0013 of device 0x1E and resets to 0xFFFD.
// - The lane 3 counter sits at 0x0014 of device 0x1E and resets to 0xFFFD.
// - The status register sits at 0x0015 of device 0x1E and resets to 0x0000.
// - Status bit 11 flags a decode error on the lane picked by the lane select.
// - Status bit 10 flags loss of signal on the selected lane.
// - Status bit 9 is set by a lane alignment buffer fault and stays one until the status register is read.
// - Status bits 3:0 show the sync rotation pointer.
`default_nettype none

module lsles_regs
	import lsles_pkg::*;
#(
	parameter logic [4:0] PORT_ADDR = LSLES_PORT_ADDR_DEF
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Management pins
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	// Configuration
	input wire lsles_mode_t mode,
	input wire logic [1:0] pattern_select,
	input wire logic [1:0] status_lane_select,
	// Lane conditions
	input wire lsles_lane_in_t [3:0] lane_in,
	input wire logic lane_alignment_buffer_fault,
	input wire logic [3:0] system_side_sync_rotation
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic mdc_q1, mdc_q2, mdc_q3, mdio_q1, mdio_q2;
	logic mdc_rise;

	// Two stages for each pin, a third on the clock for edge finding
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			mdc_q1 <= 1'b0;
			mdc_q2 <= 1'b0;
			mdc_q3 <= 1'b0;
			mdio_q1 <= 1'b1;
			mdio_q2 <= 1'b1;
		end else begin
			mdc_q1 <= mdc;
			mdc_q2 <= mdc_q1;
			mdc_q3 <= mdc_q2;
			mdio_q1 <= mdio_in;
			mdio_q2 <= mdio_q1;
		end
	end

	assign mdc_rise = mdc_q2 & ~mdc_q3;

	// ---------------------------------------------------------------
	// Frame decode
	// ---------------------------------------------------------------
	lsles_state_t state_r;
	logic [5:0] cnt_r;
	logic [11:0] hdr_r;
	logic [15:0] shift_r, addr_r, rd_word, status_word;
	logic rd_go_r, hdr_match, frame_read, rd_take, status_rd;
	logic [15:0] lane_count [1:3];
	logic decode_lat_r, los_lat_r, fifo_lat_r, sync_lat_r;

	assign hdr_match = (hdr_r[9:5] == PORT_ADDR) && (hdr_r[4:0] == LSLES_DEV_ADDR);
	assign frame_read = hdr_match && ((hdr_r[11:10] == LSLES_OP_READ)
		|| (hdr_r[11:10] == LSLES_OP_RINC));
	assign rd_take = mdc_rise && (state_r == S_TA1) && frame_read;
	assign status_rd = rd_take && (addr_r == LSLES_STATUS_OFS);

	// Status word with reserved fields held at zero
	always_comb begin
		status_word = LSLES_STATUS_RESET;
		status_word[LSLES_DECODE_BIT] = decode_lat_r;
		status_word[LSLES_LOS_BIT] = los_lat_r;
		status_word[LSLES_FIFO_BIT] = fifo_lat_r;
		status_word[LSLES_SYNC_BIT] = sync_lat_r;
		status_word[LSLES_ROT_LSB +: 4] = system_side_sync_rotation;
	end

	// Read data selection, unmapped offsets read zero
	always_comb begin
		case (addr_r)
			LSLES_LANE1_OFS: rd_word = lane_count[1];
			LSLES_LANE2_OFS: rd_word = lane_count[2];
			LSLES_LANE3_OFS: rd_word = lane_count[3];
			LSLES_STATUS_OFS: rd_word = status_word;
			default: rd_word = 16'h0000;
		endcase
	end

	// Frame sequencer, advanced on each management clock rise
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_r <= S_PRE;
			cnt_r <= 6'h00;
			hdr_r <= 12'h000;
			shift_r <= 16'h0000;
			addr_r <= LSLES_ADDR_RESET;
			rd_go_r <= 1'b0;
		end else if (mdc_rise) begin
			case (state_r)
				S_PRE: begin
					if (mdio_q2) begin
						cnt_r <= (cnt_r == LSLES_PRE_BITS) ? cnt_r : cnt_r + 6'h01;
					end else if (cnt_r == LSLES_PRE_BITS) begin
						state_r <= S_ST;
					end else begin
						cnt_r <= 6'h00;
					end
				end
				S_ST: begin
					cnt_r <= 6'h00;
					state_r <= mdio_q2 ? S_PRE : S_HDR;
				end
				S_HDR: begin
					hdr_r <= {hdr_r[10:0], mdio_q2};
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r == LSLES_HDR_LAST) begin
						state_r <= S_TA1;
					end
				end
				S_TA1: begin
					state_r <= S_TA2;
					rd_go_r <= frame_read;
					if (frame_read) begin
						shift_r <= rd_word;
					end
				end
				S_TA2: begin
					state_r <= S_DATA;
					cnt_r <= 6'h00;
					if (rd_go_r) begin
						shift_r <= {shift_r[14:0], 1'b0};
					end
				end
				S_DATA: begin
					cnt_r <= cnt_r + 6'h01;
					shift_r <= {shift_r[14:0], rd_go_r ? 1'b0 : mdio_q2};
					if (cnt_r == LSLES_DATA_LAST) begin
						state_r <= S_PRE;
						cnt_r <= 6'h00;
						// Data writes land nowhere: every register here is read-only
						if (hdr_match && hdr_r[11:10] == LSLES_OP_ADDR) begin
							addr_r <= {shift_r[14:0], mdio_q2};
						end else if (hdr_match && hdr_r[11:10] == LSLES_OP_RINC) begin
							addr_r <= addr_r + 16'h0001;
						end
					end
				end
				default: state_r <= S_PRE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Pin driver
	// ---------------------------------------------------------------
	// Drive turnaround zero then data MSB first, release after bit 0
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			mdio_out <= 1'b0;
			mdio_oe_n <= 1'b1;
		end else if (mdc_rise) begin
			if (state_r == S_TA1 && frame_read) begin
				mdio_out <= 1'b0;
				mdio_oe_n <= 1'b0;
			end else if ((state_r == S_TA2 || state_r == S_DATA) && rd_go_r
				&& !(state_r == S_DATA && cnt_r == LSLES_DATA_LAST)) begin
				mdio_out <= shift_r[15];
			end else begin
				mdio_out <= 1'b0;
				mdio_oe_n <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Lane counters
	// ---------------------------------------------------------------
	for (genvar i = 1; i <= 3; i++) begin : g_lane
		lsles_err_counter #(
			.WIDTH(16),
			.RESET_VAL(LSLES_COUNT_RESET)
		) u_cnt (
			.sys_clk(sys_clk),
			.reset(reset),
			.mode(mode),
			.pattern_select(pattern_select),
			.lane(lane_in[i]),
			.read_clear(rd_take && (addr_r == LSLES_LANE1_OFS + 16'(i - 1))),
			.count_r(lane_count[i])
		);
	end

	// ---------------------------------------------------------------
	// Status latches
	// ---------------------------------------------------------------
	// A read reloads each latch from the live condition so no event is lost
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			decode_lat_r <= 1'b0;
			los_lat_r <= 1'b0;
			fifo_lat_r <= 1'b0;
			sync_lat_r <= 1'b0;
		end else if (status_rd) begin
			decode_lat_r <= lane_in[status_lane_select].decode_err;
			los_lat_r <= lane_in[status_lane_select].los;
			fifo_lat_r <= lane_alignment_buffer_fault;
			sync_lat_r <= lane_in[status_lane_select].sync_ok;
		end else begin
			decode_lat_r <= decode_lat_r | lane_in[status_lane_select].decode_err;
			los_lat_r <= los_lat_r | lane_in[status_lane_select].los;
			fifo_lat_r <= fifo_lat_r | lane_alignment_buffer_fault;
			sync_lat_r <= sync_lat_r & lane_in[status_lane_select].sync_ok;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence read_turn_s;
		mdc_rise && state_r == S_TA1 && frame_read;
	endsequence

	sequence first_bit_s;
		!mdio_oe_n && !mdio_out;
	endsequence

	read_load_a: assert property (read_turn_s |=> shift_r == $past(rd_word))
		else $error("read word not captured");
	turnaround_a: assert property (read_turn_s |=> first_bit_s)
		else $error("turnaround zero not driven");
	decode_latch_a: assert property (
		lane_in[status_lane_select].decode_err |=> decode_lat_r)
		else $error("decode fault not latched");
	los_latch_a: assert property (lane_in[status_lane_select].los |=> los_lat_r)
		else $error("signal loss not latched");
	fifo_latch_a: assert property (lane_alignment_buffer_fault |=> fifo_lat_r)
		else $error("alignment fault not latched");
	latch_hold_a: assert property ((decode_lat_r && !status_rd) |=> decode_lat_r)
		else $error("latched fault dropped before read");
	sync_low_a: assert property (!lane_in[status_lane_select].sync_ok |=> !sync_lat_r)
		else $error("sync loss not held low");
	status_fields_a: assert property (
		(read_turn_s ##0 (addr_r == LSLES_STATUS_OFS)) |=> (shift_r[15:12] == 4'h0
		&& shift_r[7:4] == 4'h0 && shift_r[3:0] == $past(system_side_sync_rotation)))
		else $error("status reserved or rotation field wrong");

endmodule // lsles_regs

`default_nettype wire

// file: verif/lsles_mdio_host.sv
// Management host model that sends frames on the management pins
`default_nettype none

module lsles_mdio_host (
	// Management pins
	output logic mdc,
	output logic host_en,
	output logic host_bit,
	input wire logic mdio_wire
);
	timeunit 1ns;
	timeprecision 1ns;

	// Clock stands still low and the line is released between frames
	initial begin
		mdc = 1'b0;
		host_en = 1'b0;
		host_bit = 1'b0;
	end

	// Preamble, start, op, port, device, turnaround, 16 data bits MSB first
	task automatic frame(input logic [1:0] op, input logic [4:0] dev,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] f;
		f = {32'hFFFFFFFF, 2'h0, op, 5'h00, dev, 2'h2, wd};
		rd = 16'h0000;
		#13;
		for (int i = 63; i >= 0; i--) begin
			host_en = !(op[1] && i < 18); // Released from turnaround on reads
			host_bit = f[i];
			#160 mdc = 1'b1;
			if (op[1] && i < 16)
				rd = {rd[14:0], mdio_wire};
			#160 mdc = 1'b0;
		end
		host_en = 1'b0;
		// Pad to a whole number of core clock periods so frames never drift onto its edge
		#27;
	endtask
endmodule // lsles_mdio_host

`default_nettype wire

// file: verif/tb_lsles_regs.sv
// Self-checking bench for the low-speed lane error and status registers
`default_nettype none

module tb_lsles_regs import lsles_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic mdc, host_en, host_bit, mdio_out, mdio_oe_n, mdio_wire;
	lsles_mode_t mode = LSLES_MODE_KR_KX;
	logic [1:0] psel = 2'h0;
	logic [1:0] lsel = 2'h0;
	lsles_lane_in_t [3:0] lane_in = '0;
	logic fifo_fault = 1'b0;
	logic [3:0] rot = 4'h0;
	int failures = 0;
	int num_checks = 0;
	int seed = 56751;
	int cycles = 0;
	int cnt [1:3];
	logic [15:0] rd;

	// Line has a pull-up, so nobody driving reads one
	assign mdio_wire = !mdio_oe_n ? mdio_out : (host_en ? host_bit : 1'b1);

	lsles_regs u_lsles_regs (
		.sys_clk(sys_clk), .reset(reset), .mdc(mdc), .mdio_in(mdio_wire),
		.mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mode(mode),
		.pattern_select(psel), .status_lane_select(lsel), .lane_in(lane_in),
		.lane_alignment_buffer_fault(fifo_fault), .system_side_sync_rotation(rot)
	);

	lsles_mdio_host u_lsles_mdio_host (
		.mdc(mdc), .host_en(host_en), .host_bit(host_bit), .mdio_wire(mdio_wire)
	);

	// Clock and hang guard
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			close_out();
		end
	end

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rd_reg(input logic [15:0] ofs, output logic [15:0] v);
		logic [15:0] d;
		u_lsles_mdio_host.frame(LSLES_OP_ADDR, LSLES_DEV_ADDR, ofs, d);
		u_lsles_mdio_host.frame(LSLES_OP_READ, LSLES_DEV_ADDR, 16'h0000, v);
	endtask

	// Random error pulses on lanes 1 to 3, counted by the model per mode
	task automatic burst(input int n);
		lsles_lane_in_t [3:0] v;
		logic hit;
		for (int k = 0; k < n; k++) begin
			@(posedge sys_clk) #2;
			v = lane_in;
			for (int l = 1; l < 4; l++) begin
				v[l] = {6'($random(seed)), v[l].los, v[l].sync_ok};
				case (mode)
					LSLES_MODE_KR_KX: hit = v[l].decode_err;
					LSLES_MODE_10G: hit = v[l].align_err;
					default: hit = v[l].pattern_err[psel];
				endcase
				if (hit && cnt[l] < 65535)
					cnt[l]++;
			end
			lane_in = v;
		end
		@(posedge sys_clk) #2;
		for (int l = 1; l < 4; l++)
			lane_in[l] = {6'h00, lane_in[l].los, lane_in[l].sync_ok};
	endtask

	// Read lanes 1 to 3 with read and increment, each read clears
	task automatic check_lanes();
		logic [15:0] v;
		u_lsles_mdio_host.frame(LSLES_OP_ADDR, LSLES_DEV_ADDR, 16'h0012, v);
		for (int l = 1; l < 4; l++) begin
			u_lsles_mdio_host.frame(LSLES_OP_RINC, LSLES_DEV_ADDR, 16'h0000, v);
			check("lane count", 16'(cnt[l]), v);
			cnt[l] = 0;
		end
	endtask

	task automatic close_out();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		foreach (cnt[l])
			cnt[l] = 65533;
		repeat (2) @(posedge sys_clk);
		#2 reset = 1'b0;
		repeat (4) @(posedge sys_clk);
		rd_reg(16'h0013, rd);
		check("lane2 reset", 16'hFFFD, rd);
		rd_reg(16'h0014, rd);
		check("lane3 reset", 16'hFFFD, rd);
		rd_reg(16'h0015, rd);
		check("status reset", 16'h0000, rd);
		cnt[2] = 0;
		cnt[3] = 0;
		$display("test reset values done");
		for (int m = 0; m < 6; m++) begin
			@(posedge sys_clk) #2;
			mode = lsles_mode_t'(m > 2 ? 2 : m);
			psel = 2'(m - 2);
			burst(40);
			check_lanes();
		end
		$display("test counting modes done");
		@(posedge sys_clk) #2 mode = LSLES_MODE_KR_KX;
		burst(20);
		u_lsles_mdio_host.frame(LSLES_OP_ADDR, LSLES_DEV_ADDR, 16'h0013, rd);
		u_lsles_mdio_host.frame(LSLES_OP_ADDR, 5'h01, 16'h0014, rd);
		u_lsles_mdio_host.frame(LSLES_OP_READ, 5'h01, 16'h0000, rd);
		check("other device", 16'hFFFF, rd);
		u_lsles_mdio_host.frame(LSLES_OP_READ, LSLES_DEV_ADDR, 16'h0000, rd);
		check("lane2 kept", 16'(cnt[2]), rd);
		cnt[2] = 0;
		u_lsles_mdio_host.frame(LSLES_OP_WRITE, LSLES_DEV_ADDR, 16'hFFFF, rd);
		check_lanes();
		rd_reg(16'h0020, rd);
		check("unmapped", 16'h0000, rd);
		$display("test refusals done");
		@(posedge sys_clk) #2;
		lsel = 2'($random(seed));
		rot = 4'($random(seed));
		lane_in[lsel].sync_ok = 1'b1;
		rd_reg(16'h0015, rd);
		check("status first", {12'h000, rot}, rd);
		@(posedge sys_clk) #2;
		lane_in[lsel].los = 1'b1;
		lane_in[lsel].decode_err = 1'b1;
		lane_in[lsel].sync_ok = 1'b0;
		fifo_fault = 1'b1;
		@(posedge sys_clk) #2;
		lane_in[lsel].los = 1'b0;
		lane_in[lsel].decode_err = 1'b0;
		lane_in[lsel].sync_ok = 1'b1;
		fifo_fault = 1'b0;
		if (lsel != 2'h0)
			cnt[lsel]++;
		rd_reg(16'h0015, rd);
		check("status latched", {8'h0E, 4'h0, rot}, rd);
		@(posedge sys_clk) #2 lane_in[2'(lsel + 1)].los = 1'b1;
		@(posedge sys_clk) #2 lane_in[2'(lsel + 1)].los = 1'b0;
		u_lsles_mdio_host.frame(LSLES_OP_WRITE, LSLES_DEV_ADDR, 16'hFFFF, rd);
		u_lsles_mdio_host.frame(LSLES_OP_READ, LSLES_DEV_ADDR, 16'h0000, rd);
		check("status reloaded", {8'h01, 4'h0, rot}, rd);
		check_lanes();
		$display("test status done");
		close_out();
	end
endmodule // tb_lsles_regs

`default_nettype wire
